// *** rtl/car_defines.vh ***
// Constants for the configuration access router: offsets, fields, codes and timing.
`ifndef CAR_DEFINES_VH
`define CAR_DEFINES_VH

`define CAR_OFF_INDEX 8'h00
`define CAR_OFF_DATA 8'h04
`define CAR_OFF_XADDR 8'h08
`define CAR_OFF_XDATA 8'h0c
`define CAR_OFF_SECBUS 8'h10
`define CAR_OFF_SUBBUS 8'h14
`define CAR_OFF_CTRL 8'h18
`define CAR_OFF_STATUS 8'h1c

`define CAR_IDX_EN 31
`define CAR_IDX_MASK 32'h80fffffc
`define CAR_IDX_BUS 23:16
`define CAR_IDX_DEV 15:11
`define CAR_IDX_FN 10:8
`define CAR_IDX_REG 7:2
`define CAR_XA_MASK 32'h0ffffffc
`define CAR_XA_BUS 27:20
`define CAR_XA_DEV 19:15
`define CAR_XA_FN 14:12
`define CAR_XA_EXT 11:8
`define CAR_XA_REG 7:2
`define CAR_CTRL_TOEN 0
`define CAR_CTRL_DIS 7:4

`define CAR_CPL_SC 3'h0
`define CAR_CPL_UR 3'h1
`define CAR_CPL_CRS 3'h2
`define CAR_CPL_CA 3'h4

`define CAR_ROUTE_INT 3'h0
`define CAR_ROUTE_GL_T0 3'h1
`define CAR_ROUTE_GL_T1 3'h2
`define CAR_ROUTE_GL_ABORT 3'h3
`define CAR_ROUTE_SOUTH_T0 3'h4
`define CAR_ROUTE_SOUTH_T1 3'h5

`define CAR_FMT_RD 3'h0
`define CAR_FMT_WR 3'h2
`define CAR_TYPE_CFG0 5'h04
`define CAR_TYPE_CFG1 5'h05

`define CAR_DEV_HOST 5'h00
`define CAR_DEV_GBRIDGE 5'h01
`define CAR_DEV_GFX 5'h02
`define CAR_DEV_AUX 5'h07

`define CAR_ALL_ONES 32'hffffffff
`define CAR_CPL_TIMEOUT_US 50
`define CAR_CLK_MHZ 50

`endif

// *** rtl/car_tlp_hdr.v ***
// Packs the format/type byte and header bytes 8 to 11 of a configuration request.
`timescale 1ns/1ns
`include "car_defines.vh"

module car_tlp_hdr (
  input wire [7:0] bus,
  input wire [4:0] dev,
  input wire [2:0] fn,
  input wire [3:0] ext_reg,
  input wire [5:0] dw_reg,
  input wire is_write,
  input wire is_type1,
  output wire [7:0] fmt_type,
  output wire [31:0] hdr_dw2
);

  assign fmt_type = {is_write ? `CAR_FMT_WR : `CAR_FMT_RD,
                     is_type1 ? `CAR_TYPE_CFG1 : `CAR_TYPE_CFG0};

  // Byte 8 sits in the top lane, as header bytes go out most significant first.
  // bus device function
  assign hdr_dw2 = {bus, dev, fn, 4'h0, ext_reg, dw_reg, 2'h0};

endmodule

// *** rtl/car_router.v ***
// Configuration access router: APB register file, bus-0 functions and link request engine.
`timescale 1ns/1ns
`include "car_defines.vh"

// Notes on behaviour
// - decode bus bits 23:16 and device
// - existing enabled internal function claims request
// - TLP byte 8 bus, byte 9 device/function
// - byte 10 extended, byte 11 dword register
// - secondary bus match gives graphics Type 0
// - non-zero device on secondary bus aborts
// - bus in range gives graphics Type 1
// - extended writes posted here, non-posted on links
// - unclaimed requests go to south link
// - south link Type 0 on bus zero
// - retry status reissues request without limit
// - reissue keeps fields, new sequence number
// - hold host answer until final completion
// - byte lanes allowed, index register dword only
// - multi-byte fields are little-endian
// - reserved locations read zero, ignore writes
// - full reset loads defaults, some from straps
// - data port works only with enable bit
// - bus-0 devices 0,1,2,7 are internal
// - Type 1 range is above secondary, to subordinate
module car_router #(
  parameter INT_AW = 4,
  parameter [15:0] REQ_ID = 16'h0000
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [3:0] strap_func_disable,
  output reg tlp_valid,
  input wire tlp_ready,
  output reg tlp_to_graphics,
  output reg [7:0] tlp_fmt_type,
  output reg [31:0] tlp_hdr_dw2,
  output reg [7:0] tlp_tag,
  output reg [11:0] tlp_seq,
  output reg [15:0] tlp_req_id,
  output reg [3:0] tlp_be,
  output reg [31:0] tlp_data,
  input wire cpl_valid,
  input wire [2:0] cpl_status,
  input wire [31:0] cpl_data
);

  localparam ST_IDLE = 2'b00;
  localparam ST_ISSUE = 2'b01;
  localparam ST_WAIT = 2'b10;
  localparam INT_DW = 1 << INT_AW;
  localparam integer TO_CYC_I = `CAR_CPL_TIMEOUT_US * `CAR_CLK_MHZ;
  localparam [11:0] TO_CYC = TO_CYC_I[11:0];

  function int_hit;
    input [4:0] dev;
    begin
      int_hit = (dev == `CAR_DEV_HOST) || (dev == `CAR_DEV_GBRIDGE) ||
                (dev == `CAR_DEV_GFX) || (dev == `CAR_DEV_AUX);
    end
  endfunction

  function [1:0] int_idx;
    input [4:0] dev;
    begin
      case (dev)
        `CAR_DEV_HOST: int_idx = 2'h0;
        `CAR_DEV_GBRIDGE: int_idx = 2'h1;
        `CAR_DEV_GFX: int_idx = 2'h2;
        default: int_idx = 2'h3;
      endcase
    end
  endfunction

  function [2:0] route_of;
    input [7:0] bus;
    input [4:0] dev;
    input [2:0] fn;
    input [3:0] dis;
    input [7:0] sec;
    input [7:0] sub;
    begin
      if (bus == 8'h00)
      begin
        if (int_hit(dev) && fn == 3'h0 && !dis[int_idx(dev)])
          route_of = `CAR_ROUTE_INT;
        else
          route_of = `CAR_ROUTE_SOUTH_T0;
      end
      else if (bus == sec)
        route_of = (dev == 5'h00) ? `CAR_ROUTE_GL_T0 : `CAR_ROUTE_GL_ABORT;
      else if (bus > sec && bus <= sub)
        route_of = `CAR_ROUTE_GL_T1;
      else
        route_of = `CAR_ROUTE_SOUTH_T1;
    end
  endfunction

  reg [2:0] strap_s1_ff;
  reg [3:0] strap_s2_ff;
  reg [3:0] strap_s3_ff;
  reg [3:0] strap_s1w_ff;
  reg [1:0] settle_ff;
  reg strap_done_ff;
  reg [31:0] index_ff;
  reg [31:0] xaddr_ff;
  reg [7:0] sec_ff;
  reg [7:0] sub_ff;
  reg to_en_ff;
  reg [3:0] dis_ff;
  reg [1:0] state_ff;
  reg [2:0] last_status_ff;
  reg last_timeout_ff;
  reg [7:0] retry_cnt_ff;
  reg [11:0] to_cnt_ff;
  reg [11:0] seq_south_ff;
  reg [11:0] seq_gl_ff;
  reg [7:0] tag_ff;
  reg owe_answer_ff;
  reg req_write_ff;
  reg req_gl_ff;
  reg req_type1_ff;
  reg [7:0] req_bus_ff;
  reg [4:0] req_dev_ff;
  reg [2:0] req_fn_ff;
  reg [3:0] req_ext_ff;
  reg [5:0] req_reg_ff;
  reg [31:0] int_mem [0:4*INT_DW-1];
  reg [4*INT_DW-1:0] int_vld_ff;

  wire access = psel && penable && !pready && strap_done_ff && state_ff == ST_IDLE;
  wire is_data = paddr == `CAR_OFF_DATA;
  wire is_xdata = paddr == `CAR_OFF_XDATA;
  wire [7:0] a_bus = is_xdata ? xaddr_ff[`CAR_XA_BUS] : index_ff[`CAR_IDX_BUS];
  wire [4:0] a_dev = is_xdata ? xaddr_ff[`CAR_XA_DEV] : index_ff[`CAR_IDX_DEV];
  wire [2:0] a_fn = is_xdata ? xaddr_ff[`CAR_XA_FN] : index_ff[`CAR_IDX_FN];
  wire [3:0] a_ext = is_xdata ? xaddr_ff[`CAR_XA_EXT] : 4'h0;
  wire [5:0] a_reg = is_xdata ? xaddr_ff[`CAR_XA_REG] : index_ff[`CAR_IDX_REG];
  wire [2:0] a_route = route_of(a_bus, a_dev, a_fn, dis_ff, sec_ff, sub_ff);
  wire a_reserved = (a_ext != 4'h0) || (a_reg >= INT_DW);
  wire [INT_AW+1:0] a_word = {int_idx(a_dev), a_reg[INT_AW-1:0]};
  wire [31:0] a_old = int_vld_ff[a_word] ? int_mem[a_word] : 32'h0;
  wire [7:0] h_fmt_type;
  wire [31:0] h_dw2;
  reg [31:0] a_merged;
  integer b;

  always @*
  begin
    a_merged = a_old;
    for (b = 0; b < 4; b = b + 1)
      if (pstrb[b])
        a_merged[8*b +: 8] = pwdata[8*b +: 8];
  end

  car_tlp_hdr u_hdr (
    .bus(a_bus),
    .dev(a_dev),
    .fn(a_fn),
    .ext_reg(a_ext),
    .dw_reg(a_reg),
    .is_write(pwrite),
    .is_type1(a_route == `CAR_ROUTE_GL_T1 || a_route == `CAR_ROUTE_SOUTH_T1),
    .fmt_type(h_fmt_type),
    .hdr_dw2(h_dw2)
  );

  // Strap pins pass three stages; the defaults load once they have settled.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_s1w_ff <= 4'h0;
      strap_s2_ff <= 4'h0;
      strap_s3_ff <= 4'h0;
      settle_ff <= 2'h0;
    end
    else
    begin
      strap_s1w_ff <= strap_func_disable;
      strap_s2_ff <= strap_s1w_ff;
      strap_s3_ff <= strap_s2_ff;
      if (settle_ff != 2'h3)
        settle_ff <= settle_ff + 2'h1;
    end
  end

  always @(posedge pclk)
  begin
    if (access && !is_xdata && is_data == 1'b0)
      strap_s1_ff <= 3'h0;
    else
      strap_s1_ff <= strap_s1_ff;
  end

  always @(posedge pclk)
  begin
    if (access && (is_data || is_xdata) && pwrite && a_route == `CAR_ROUTE_INT &&
        !a_reserved && (!is_data || index_ff[`CAR_IDX_EN]))
      int_mem[a_word] <= a_merged;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_done_ff <= 1'b0;
      index_ff <= 32'h0;
      xaddr_ff <= 32'h0;
      sec_ff <= 8'h00;
      sub_ff <= 8'h00;
      to_en_ff <= 1'b0;
      dis_ff <= 4'h0;
      int_vld_ff <= {4*INT_DW{1'b0}};
      state_ff <= ST_IDLE;
      last_status_ff <= `CAR_CPL_SC;
      last_timeout_ff <= 1'b0;
      retry_cnt_ff <= 8'h00;
      to_cnt_ff <= 12'h000;
      seq_south_ff <= 12'h000;
      seq_gl_ff <= 12'h000;
      tag_ff <= 8'h00;
      owe_answer_ff <= 1'b0;
      req_write_ff <= 1'b0;
      req_gl_ff <= 1'b0;
      req_type1_ff <= 1'b0;
      req_bus_ff <= 8'h00;
      req_dev_ff <= 5'h00;
      req_fn_ff <= 3'h0;
      req_ext_ff <= 4'h0;
      req_reg_ff <= 6'h00;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      tlp_valid <= 1'b0;
      tlp_to_graphics <= 1'b0;
      tlp_fmt_type <= 8'h00;
      tlp_hdr_dw2 <= 32'h0;
      tlp_tag <= 8'h00;
      tlp_seq <= 12'h000;
      tlp_req_id <= 16'h0000;
      tlp_be <= 4'h0;
      tlp_data <= 32'h0;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (!strap_done_ff && settle_ff == 2'h3 && strap_s2_ff == strap_s3_ff)
      begin
        dis_ff <= strap_s3_ff;
        strap_done_ff <= 1'b1;
      end
      case (state_ff)
        ST_IDLE:
        begin
          if (access)
          begin
            prdata <= 32'h0;
            pready <= 1'b1;
            case (paddr)
              `CAR_OFF_INDEX:
              begin
                if (pwrite && pstrb == 4'hf)
                  index_ff <= pwdata & `CAR_IDX_MASK;
                prdata <= index_ff;
              end
              `CAR_OFF_XADDR:
              begin
                if (pwrite && pstrb == 4'hf)
                  xaddr_ff <= pwdata & `CAR_XA_MASK;
                prdata <= xaddr_ff;
              end
              `CAR_OFF_SECBUS:
              begin
                if (pwrite && pstrb[0])
                  sec_ff <= pwdata[7:0];
                prdata <= {24'h0, sec_ff};
              end
              `CAR_OFF_SUBBUS:
              begin
                if (pwrite && pstrb[0])
                  sub_ff <= pwdata[7:0];
                prdata <= {24'h0, sub_ff};
              end
              `CAR_OFF_CTRL:
              begin
                if (pwrite && pstrb[0])
                begin
                  to_en_ff <= pwdata[`CAR_CTRL_TOEN];
                  dis_ff <= pwdata[`CAR_CTRL_DIS];
                end
                prdata <= {24'h0, dis_ff, 3'h0, to_en_ff};
              end
              `CAR_OFF_STATUS:
                prdata <= {16'h0, retry_cnt_ff, 2'h0, last_timeout_ff,
                           last_status_ff, state_ff};
              `CAR_OFF_DATA, `CAR_OFF_XDATA:
              begin
                if (is_data && !index_ff[`CAR_IDX_EN])
                  prdata <= 32'h0;
                else if (a_route == `CAR_ROUTE_INT)
                begin
                  if (!a_reserved)
                  begin
                    if (pwrite)
                      int_vld_ff[a_word] <= 1'b1;
                    else
                      prdata <= a_old;
                  end
                end
                else if (a_route == `CAR_ROUTE_GL_ABORT)
                begin
                  prdata <= pwrite ? 32'h0 : `CAR_ALL_ONES;
                  last_status_ff <= `CAR_CPL_UR;
                end
                else
                begin
                  req_write_ff <= pwrite;
                  req_gl_ff <= a_route == `CAR_ROUTE_GL_T0 || a_route == `CAR_ROUTE_GL_T1;
                  req_bus_ff <= a_bus;
                  req_dev_ff <= a_dev;
                  req_fn_ff <= a_fn;
                  req_ext_ff <= a_ext;
                  req_reg_ff <= a_reg;
                  req_type1_ff <= h_fmt_type[0];
                  tlp_valid <= 1'b1;
                  tlp_to_graphics <= a_route == `CAR_ROUTE_GL_T0 ||
                                     a_route == `CAR_ROUTE_GL_T1;
                  tlp_fmt_type <= h_fmt_type;
                  tlp_hdr_dw2 <= h_dw2;
                  tlp_tag <= tag_ff;
                  tlp_req_id <= REQ_ID;
                  tlp_be <= pstrb;
                  tlp_data <= pwdata;
                  tag_ff <= tag_ff + 8'h01;
                  retry_cnt_ff <= 8'h00;
                  last_timeout_ff <= 1'b0;
                  if (a_route == `CAR_ROUTE_GL_T0 || a_route == `CAR_ROUTE_GL_T1)
                  begin
                    tlp_seq <= seq_gl_ff;
                    seq_gl_ff <= seq_gl_ff + 12'h001;
                  end
                  else
                  begin
                    tlp_seq <= seq_south_ff;
                    seq_south_ff <= seq_south_ff + 12'h001;
                  end
                  state_ff <= ST_ISSUE;
                  owe_answer_ff <= !(is_xdata && pwrite);
                  pready <= is_xdata && pwrite;
                end
              end
              default:
                pslverr <= 1'b1;
            endcase
          end
        end
        ST_ISSUE:
        begin
          if (tlp_ready)
          begin
            tlp_valid <= 1'b0;
            to_cnt_ff <= 12'h000;
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          to_cnt_ff <= to_cnt_ff + 12'h001;
          if (cpl_valid)
          begin
            last_status_ff <= cpl_status;
            if (cpl_status == `CAR_CPL_CRS)
            begin
              tlp_valid <= 1'b1;
              retry_cnt_ff <= retry_cnt_ff + 8'h01;
              if (req_gl_ff)
              begin
                tlp_seq <= seq_gl_ff;
                seq_gl_ff <= seq_gl_ff + 12'h001;
              end
              else
              begin
                tlp_seq <= seq_south_ff;
                seq_south_ff <= seq_south_ff + 12'h001;
              end
              state_ff <= ST_ISSUE;
            end
            else
            begin
              pready <= owe_answer_ff;
              prdata <= (cpl_status == `CAR_CPL_SC && !req_write_ff) ? cpl_data :
                        (req_write_ff ? 32'h0 : `CAR_ALL_ONES);
              owe_answer_ff <= 1'b0;
              state_ff <= ST_IDLE;
            end
          end
          else if (to_en_ff && to_cnt_ff == TO_CYC - 12'h001)
          begin
            last_timeout_ff <= 1'b1;
            pready <= owe_answer_ff;
            prdata <= req_write_ff ? 32'h0 : `CAR_ALL_ONES;
            owe_answer_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule

// *** bench/car_sva.sv ***
// Port checker for the configuration access router.
`timescale 1ns/1ns
module car_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire tlp_valid,
  input wire tlp_ready,
  input wire tlp_to_graphics,
  input wire [7:0] tlp_fmt_type,
  input wire [31:0] tlp_hdr_dw2,
  input wire [7:0] tlp_tag,
  input wire [11:0] tlp_seq,
  input wire cpl_valid,
  input wire [2:0] cpl_status,
  input wire [31:0] cpl_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [7:0] tag_ff;
  reg [31:0] hdr_ff;
  reg [11:0] seq_ff;
  wire rd_wait = psel && penable && !pwrite;
  wire fail = cpl_status == 3'h1 || cpl_status == 3'h4;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tag_ff <= 8'h00;
      hdr_ff <= 32'h0;
      seq_ff <= 12'h000;
    end
    else if (tlp_valid && tlp_ready)
    begin
      tag_ff <= tlp_tag;
      hdr_ff <= tlp_hdr_dw2;
      seq_ff <= tlp_seq;
    end
  end
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  AST_HOLD_ANSWER: assert property (tlp_valid && rd_wait |-> !pready)
    else $error("read answered before completion");
  AST_FINAL_OK: assert property (cpl_valid && cpl_status == 3'h0 && rd_wait |=>
    pready && prdata == $past(cpl_data))
    else $error("successful completion not passed on");
  AST_FAIL_ONES: assert property (cpl_valid && fail && rd_wait |=>
    pready && prdata == 32'hffffffff)
    else $error("failed read not all ones");
  AST_RETRY: assert property (cpl_valid && cpl_status == 3'h2 |=> tlp_valid && !pready)
    else $error("retry status not reissued");
  AST_REUSE: assert property (cpl_valid && cpl_status == 3'h2 |=>
    tlp_tag == tag_ff && tlp_hdr_dw2 == hdr_ff && tlp_seq != seq_ff)
    else $error("reissued request fields differ");
  AST_STAND: assert property (tlp_valid && !tlp_ready |=>
    tlp_valid && $stable(tlp_hdr_dw2) && $stable(tlp_tag))
    else $error("request changed before accept");
  AST_SOUTH_T0: assert property (tlp_valid && !tlp_to_graphics &&
    tlp_fmt_type[4:0] == 5'h04 |-> tlp_hdr_dw2[31:24] == 8'h00)
    else $error("south type 0 with non-zero bus");
  AST_SOUTH_T1: assert property (tlp_valid && !tlp_to_graphics &&
    tlp_fmt_type[4:0] == 5'h05 |-> tlp_hdr_dw2[31:24] != 8'h00)
    else $error("south type 1 with bus zero");
  AST_GFX_DEV0: assert property (tlp_valid && tlp_to_graphics &&
    tlp_fmt_type[4:0] == 5'h04 |-> tlp_hdr_dw2[23:19] == 5'h00)
    else $error("graphics type 0 to non-zero device");
  AST_HDR_PAD: assert property (tlp_valid |->
    tlp_hdr_dw2[15:12] == 4'h0 && tlp_hdr_dw2[1:0] == 2'b00)
    else $error("header pad bits set");
endmodule
bind car_router car_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .tlp_valid(tlp_valid), .tlp_ready(tlp_ready), .tlp_to_graphics(tlp_to_graphics),
  .tlp_fmt_type(tlp_fmt_type), .tlp_hdr_dw2(tlp_hdr_dw2), .tlp_tag(tlp_tag),
  .tlp_seq(tlp_seq), .cpl_valid(cpl_valid), .cpl_status(cpl_status), .cpl_data(cpl_data));

// *** bench/car_link_model.sv ***
// Link partner model: accepts requests and returns completions.
`timescale 1ns/1ns
module car_link_model (
  input wire pclk,
  input wire tlp_valid,
  input wire tlp_to_graphics,
  input wire [7:0] tlp_fmt_type,
  input wire [31:0] tlp_hdr_dw2,
  input wire [1:0] n_retry,
  input wire [2:0] fin_st,
  input wire [3:0] dly,
  output reg tlp_ready = 1'b0,
  output reg cpl_valid = 1'b0,
  output reg [2:0] cpl_status = 3'h0,
  output reg [31:0] cpl_data = 32'h0,
  output reg [31:0] seen_hdr = 32'h0,
  output reg [7:0] seen_ft = 8'h00,
  output reg seen_gfx = 1'b0,
  output reg [7:0] seen_n = 8'h00
);
  integer tries = 0;
  always
  begin
    @(posedge pclk);
    #1;
    // Idle completion lines toggle so stale values never look valid.
    cpl_data = ~cpl_data;
    cpl_status = ~cpl_status;
    if (tlp_valid === 1'b1)
    begin
      seen_hdr = tlp_hdr_dw2;
      seen_ft = tlp_fmt_type;
      seen_gfx = tlp_to_graphics;
      repeat (dly) @(posedge pclk);
      #1;
      tlp_ready = 1'b1;
      @(posedge pclk);
      #1;
      tlp_ready = 1'b0;
      seen_n = seen_n + 8'h01;
      repeat (dly) @(posedge pclk);
      #1;
      cpl_valid = 1'b1;
      cpl_data = ~seen_hdr;
      if (seen_gfx && tries < n_retry)
      begin
        cpl_status = 3'h2;
        tries = tries + 1;
      end
      else
      begin
        cpl_status = fin_st;
        tries = 0;
      end
      @(posedge pclk);
      #1;
      cpl_valid = 1'b0;
    end
  end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the configuration access router.
`timescale 1ns/1ns
`include "car_defines.vh"
module tb_top;
  localparam SEC = 8'h01;
  localparam SUB = 8'h04;
  localparam STRAP = 4'h8;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] pstrb = 4'h0;
  reg [1:0] n_retry = 2'h0;
  reg [2:0] fin_st = 3'h0;
  reg [3:0] dly = 4'h0;
  wire pready, pslverr, tlp_valid, tlp_ready, tlp_to_graphics, cpl_valid, seen_gfx;
  wire [31:0] prdata, tlp_hdr_dw2, cpl_data, seen_hdr;
  wire [7:0] tlp_fmt_type, tlp_tag, seen_ft, seen_n;
  wire [11:0] tlp_seq;
  wire [31:0] tlp_data;
  wire [3:0] tlp_be;
  wire [2:0] cpl_status;
  reg [31:0] rd, s2, h, seed = 32'hcb488db2;
  reg er, x, rsv;
  reg [7:0] bus, n0, pa;
  reg [4:0] dev;
  reg [2:0] fn, rt;
  reg [3:0] ext, ds, sb;
  reg [5:0] rg;
  integer bad_count = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer it, c0;
  car_router uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .strap_func_disable(STRAP), .tlp_valid(tlp_valid),
    .tlp_ready(tlp_ready), .tlp_to_graphics(tlp_to_graphics), .tlp_fmt_type(tlp_fmt_type),
    .tlp_hdr_dw2(tlp_hdr_dw2), .tlp_tag(tlp_tag), .tlp_seq(tlp_seq), .tlp_req_id(),
    .tlp_be(tlp_be), .tlp_data(tlp_data), .cpl_valid(cpl_valid), .cpl_status(cpl_status),
    .cpl_data(cpl_data));
  car_link_model u_link (.pclk(pclk), .tlp_valid(tlp_valid), .tlp_to_graphics(tlp_to_graphics),
    .tlp_fmt_type(tlp_fmt_type), .tlp_hdr_dw2(tlp_hdr_dw2), .n_retry(n_retry),
    .fin_st(fin_st), .dly(dly), .tlp_ready(tlp_ready), .cpl_valid(cpl_valid),
    .cpl_status(cpl_status), .cpl_data(cpl_data), .seen_hdr(seen_hdr), .seen_ft(seen_ft),
    .seen_gfx(seen_gfx), .seen_n(seen_n));
  always #10 pclk = ~pclk;
  function [31:0] xs(input [31:0] v);
    reg [31:0] y;
    begin
      y = v ^ (v << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [31:0] mrg(input [31:0] o, input [31:0] n, input [3:0] s);
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        mrg[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction
  function [2:0] route(input [7:0] b, input [4:0] d, input [2:0] f, input [3:0] m);
    reg hit;
    begin
      hit = (d == 5'h00 && !m[0]) || (d == 5'h01 && !m[1]) || (d == 5'h02 && !m[2]) ||
        (d == 5'h07 && !m[3]);
      if (b == 8'h00)
        route = (hit && f == 3'h0) ? `CAR_ROUTE_INT : `CAR_ROUTE_SOUTH_T0;
      else if (b == SEC)
        route = (d == 5'h00) ? `CAR_ROUTE_GL_T0 : `CAR_ROUTE_GL_ABORT;
      else if (b > SEC && b <= SUB)
        route = `CAR_ROUTE_GL_T1;
      else
        route = `CAR_ROUTE_SOUTH_T1;
    end
  endfunction
  task chk(input [8*10:1] nm, input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `CAR_OFF_INDEX, 32'h0, 4'h0);
    chk("index_rst", rd, 32'h0);
    apb(1'b0, `CAR_OFF_CTRL, 32'h0, 4'h0);
    chk("ctrl_rst", rd, {24'h0, STRAP, 4'h0});
    apb(1'b1, `CAR_OFF_INDEX, 32'h80010800, 4'h3);
    apb(1'b0, `CAR_OFF_INDEX, 32'h0, 4'h0);
    chk("index_b", rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 4'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
    apb(1'b0, `CAR_OFF_DATA, 32'h0, 4'h0);
    chk("data_off", rd, 32'h0);
    chk("no_tlp", 32'(seen_n), 32'h0);
    $display("test defaults done");
    apb(1'b1, `CAR_OFF_SECBUS, 32'(SEC), 4'hf);
    apb(1'b1, `CAR_OFF_SUBBUS, 32'(SUB), 4'hf);
    for (it = 0; it < 40; it = it + 1)
    begin
      seed = xs(seed);
      s2 = xs(seed ^ 32'h5a5a5a5a);
      bus = seed[3] ? 8'h00 : {5'h0, seed[2:0]};
      dev = seed[9] ? (seed[5:4] == 2'h3 ? 5'h07 : {3'h0, seed[5:4]}) : seed[8:4];
      fn = seed[10] ? seed[13:11] : 3'h0;
      rg = seed[20] ? seed[19:14] : {2'h0, seed[17:14]};
      x = seed[21];
      ext = (x && seed[22]) ? seed[26:23] : 4'h0;
      ds = seed[30:27];
      n_retry <= s2[7:6];
      fin_st <= s2[1] ? (s2[0] ? `CAR_CPL_CA : `CAR_CPL_UR) : `CAR_CPL_SC;
      dly <= s2[5:2];
      apb(1'b1, `CAR_OFF_CTRL, {24'h0, ds, 4'h0}, 4'hf);
      if (x)
        apb(1'b1, `CAR_OFF_XADDR, {4'h0, bus, dev, fn, ext, rg, 2'b00}, 4'hf);
      else
        apb(1'b1, `CAR_OFF_INDEX, {8'h80, bus, dev, fn, rg, 2'b00}, 4'hf);
      pa = x ? `CAR_OFF_XDATA : `CAR_OFF_DATA;
      h = {bus, dev, fn, 4'h0, ext, rg, 2'b00};
      rt = route(bus, dev, fn, ds);
      n0 = seen_n;
      rsv = ext != 4'h0 || rg >= 6'h10;
      if (rt == `CAR_ROUTE_INT)
      begin
        sb = (ext != 4'h0) ? 4'hf : s2[11:8];
        apb(1'b1, pa, seed, 4'hf);
        apb(1'b1, pa, s2, sb);
        apb(1'b0, pa, 32'h0, 4'h0);
        chk("int_data", rd, rsv ? 32'h0 : mrg(seed, s2, sb));
      end
      else if (rt == `CAR_ROUTE_GL_ABORT)
      begin
        apb(1'b0, pa, 32'h0, 4'h0);
        chk("abort", rd, 32'hffffffff);
        chk("abort_n", 32'(seen_n), 32'(n0));
      end
      else
      begin
        apb(1'b0, pa, 32'h0, 4'h0);
        chk("link_rd", rd, fin_st == `CAR_CPL_SC ? ~h : 32'hffffffff);
        chk("hdr", seen_hdr, h);
        chk("type", 32'(seen_ft), (rt == 3'h1 || rt == 3'h4) ? 32'h04 : 32'h05);
        chk("gfx", 32'(seen_gfx), 32'(rt < 3'h4));
        chk("tries", 32'(seen_n - n0), seen_gfx ? 32'(n_retry) + 1 : 32'h1);
      end
    end
    $display("test routing done");
    apb(1'b1, `CAR_OFF_XADDR, {4'h0, SEC, 5'h0, 3'h0, 4'h5, 6'h03, 2'b00}, 4'hf);
    dly <= 4'h8;
    n_retry <= 2'h1;
    fin_st <= `CAR_CPL_SC;
    n0 = seen_n;
    c0 = cyc;
    apb(1'b1, `CAR_OFF_XDATA, 32'h1234abcd, 4'hf);
    chk("posted", 32'(cyc - c0 < 6), 32'h1);
    while (seen_n != n0 + 8'h02)
      @(posedge pclk);
    repeat (20) @(posedge pclk);
    chk("wr_type", 32'(seen_ft), 32'h44);
    chk("wr_hdr", seen_hdr, {SEC, 8'h00, 8'h05, 8'h0c});
    chk("wr_data", tlp_data, 32'h1234abcd);
    chk("wr_be", {28'h0, tlp_be}, 32'hf);
    $display("test posted write done");
    complete_run;
  end
endmodule
